// ### verilog/stc_timer_core.v
`timescale 1ns/1ps
`include "stc_regs.vh"
module stc_timer_core #(
  parameter HAS_CAPTURE = 1,
  parameter FILT_LEN    = 4,
  parameter PRE_W       = 10
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        ce,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        extCountPin,
  input  wire        captureInputPin,
  input  wire        compOutPin,
  input  wire [5:0]  irqAck,
  output reg  [2:0]  compareOutputPins,
  output wire [5:0]  irqRequest
);

  // top value for a waveform mode
  function [15:0] topOf;
    input [3:0]  m;
    input [15:0] a;
    input [15:0] i;
    begin
      case (m)
        4'd1, 4'd5:  topOf = `STC_TOP8;
        4'd2, 4'd6:  topOf = `STC_TOP9;
        4'd3, 4'd7:  topOf = `STC_TOP10;
        4'd4, 4'd9, 4'd11, 4'd15: topOf = a;
        4'd8, 4'd10, 4'd12, 4'd14: topOf = i;
        default:     topOf = `STC_MAX;
      endcase
    end
  endfunction

  // address decode of a mapped word
  function mapped;
    input [7:0] ad;
    begin
      mapped = (ad[1:0] == 2'b00) && (ad <= `STC_PWR);
    end
  endfunction

  // timer state
  reg  [7:0]  ctrlA_reg;           // compare actions, mode low
  reg  [7:0]  ctrlB_reg;           // filter, edge, mode high, clock
  reg  [7:0]  ctrlC_reg;           // capture source select
  reg  [7:0]  temp_reg;            // shared high-byte latch
  reg  [7:0]  mask_reg;            // request enables
  reg  [5:0]  flag_reg;            // sticky request flags
  reg         pwr_reg;             // power gate, 1 = off
  reg  [15:0] cnt_reg;             // counter value
  reg  [15:0] icr_reg;             // capture value
  reg  [47:0] ocrBuf_reg;          // written compare values
  reg  [47:0] ocr_reg;             // active compare values
  reg         block_reg;           // skip match after cnt write
  reg  [PRE_W-1:0] pre_reg;        // prescaler count
  reg         extPrev_reg;         // previous ext pin level
  reg  [FILT_LEN-1:0] filt_reg;    // capture sample history
  reg         capLvl_reg;          // accepted capture level
  // bus state
  reg         awHeld_reg;          // address taken
  reg  [7:0]  awAddr_reg;          // held write address
  reg         wHeld_reg;           // data taken
  reg  [7:0]  wData_reg;           // held low data byte
  reg         wStrb_reg;           // low lane enabled

  // decoded control
  wire [3:0]  wgm = {ctrlB_reg[`STC_WGMHI_LSB+1:`STC_WGMHI_LSB],
                     ctrlA_reg[`STC_WGMLO_LSB+1:`STC_WGMLO_LSB]};
  wire [2:0]  cs  = ctrlB_reg[`STC_CS_LSB+2:`STC_CS_LSB];
  wire        pwm = (wgm != 4'd0) && (wgm != 4'd4) &&
                    (wgm != 4'd12) && (wgm != 4'd13);
  wire        run = ce & ~pwr_reg;
  wire [15:0] top = topOf(wgm, ocr_reg[15:0], icr_reg);
  wire        atTop    = (cnt_reg == top);
  wire        atBottom = (cnt_reg == `STC_BOTTOM);
  wire        atMax    = (cnt_reg == `STC_MAX);
  wire        aIsTop = pwm && (wgm == 4'd11 || wgm == 4'd15);

  // bus handshakes
  assign awready = ce & ~awHeld_reg & ~bvalid;
  assign wready  = ce & ~wHeld_reg & ~bvalid;
  assign arready = ce & ~rvalid;
  wire doWrite = ce & awHeld_reg & wHeld_reg & ~bvalid;
  wire doRead  = arvalid & arready;
  wire wen     = doWrite & wStrb_reg;
  wire [7:0] wa = awAddr_reg;
  wire [7:0] wd = wData_reg;
  wire cntLoW  = wen && wa == `STC_CNTL;
  wire icrLoW  = wen && wa == `STC_ICRL;
  wire flagW   = wen && wa == `STC_FLAGS;
  wire hiW     = wen && (wa == `STC_CNTH || wa == `STC_ICRH ||
                 (wa >= `STC_OCRL0 + 8'h04 && wa < `STC_ICRL &&
                  wa[2] == 1'b0));

  // timer tick selection
  reg tick;
  always @*
  begin
    case (cs)
      3'd1:    tick = 1'b1;
      3'd2:    tick = &pre_reg[2:0];
      3'd3:    tick = &pre_reg[5:0];
      3'd4:    tick = &pre_reg[7:0];
      3'd5:    tick = &pre_reg[9:0];
      3'd6:    tick = extPrev_reg & ~extCountPin;
      3'd7:    tick = ~extPrev_reg & extCountPin;
      default: tick = 1'b0;  // stopped
    endcase
  end
  wire go = run & tick;

  // capture trigger source and filter
  wire capSrc = ctrlC_reg[`STC_ACSEL_BIT] ? compOutPin
                                          : captureInputPin;
  wire allHi = &filt_reg;
  wire allLo = ~|filt_reg;
  wire filtOn = ctrlB_reg[`STC_FILT_BIT];
  wire lvlNext = filtOn ? (allHi ? 1'b1 : (allLo ? 1'b0 : capLvl_reg))
                        : capSrc;
  wire rise  = ctrlB_reg[`STC_EDGE_BIT];
  wire capEv = (HAS_CAPTURE != 0) && run &&
               (lvlNext != capLvl_reg) && (lvlNext == rise);

  // per channel match and force
  wire [2:0] match;
  wire [2:0] forceStb = (wen && wa == `STC_CTRLC && !pwm) ? wd[7:5]
                                                          : 3'b000;
  wire ovf = go && (pwm ? atTop : atMax);

  // prescaler, edge history, filter history
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_reg     <= {PRE_W{1'b0}};
      extPrev_reg <= 1'b0;
      filt_reg    <= {FILT_LEN{1'b0}};
      capLvl_reg  <= 1'b0;
    end
    else if (run)
    begin
      pre_reg     <= (cs == 3'd0) ? {PRE_W{1'b0}} : pre_reg + 1'b1;
      extPrev_reg <= extCountPin;
      filt_reg    <= {filt_reg[FILT_LEN-2:0], capSrc};
      capLvl_reg  <= lvlNext;
    end
  end

  // control, counter, capture, flags, latch
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlA_reg <= `STC_ZERO8;
      ctrlB_reg <= `STC_ZERO8;
      ctrlC_reg <= `STC_ZERO8;
      temp_reg  <= `STC_ZERO8;
      mask_reg  <= `STC_ZERO8;
      flag_reg  <= 6'h00;
      pwr_reg   <= `STC_PWR_RST;
      cnt_reg   <= `STC_ZERO16;
      icr_reg   <= `STC_ZERO16;
      block_reg <= 1'b0;
    end
    else if (ce)
    begin
      // direct byte registers
      if (wen && wa == `STC_CTRLA) ctrlA_reg <= wd;
      if (wen && wa == `STC_CTRLB) ctrlB_reg <= wd;
      if (wen && wa == `STC_CTRLC) ctrlC_reg <= {5'h00, wd[2:0]};
      if (wen && wa == `STC_MASK)  mask_reg  <= wd & {2'b00, `STC_FLAG_USED};
      if (wen && wa == `STC_PWR)   pwr_reg   <= wd[0];
      // latch: high write wins over low read
      if (hiW)
        temp_reg <= wd;
      else if (doRead && araddr == `STC_CNTL)
        temp_reg <= cnt_reg[15:8];
      else if (doRead && araddr == `STC_ICRL)
        temp_reg <= icr_reg[15:8];
      // counter: cpu write first
      if (cntLoW)
      begin
        cnt_reg   <= {temp_reg, wd};
        block_reg <= 1'b1;
      end
      else if (go)
      begin
        cnt_reg   <= atTop ? `STC_BOTTOM : cnt_reg + 16'h0001;
        block_reg <= 1'b0;
      end
      // capture value
      if (icrLoW)
        icr_reg <= {temp_reg, wd};
      else if (capEv)
        icr_reg <= cnt_reg;
      // set wins over clear
      flag_reg <= (flag_reg & ~((flagW ? wd[5:0] : 6'h00) | irqAck))
                | ({capEv, 1'b0, match, ovf} & `STC_FLAG_USED);
    end
  end

  assign irqRequest = flag_reg & mask_reg[5:0];

  // compare channels
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1)
    begin : g_ch
      wire [15:0] ocrA = ocr_reg[16*c+15:16*c];
      wire [1:0]  com  = ctrlA_reg[7-2*c:6-2*c];
      wire        loW  = wen && wa == `STC_OCRL0 + 8'h08 * c;
      wire        off  = (c == 0) && aIsTop;
      assign match[c] = go && !block_reg && (cnt_reg == ocrA);
      // buffer and active compare value
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          ocrBuf_reg[16*c+15:16*c] <= `STC_ZERO16;
          ocr_reg[16*c+15:16*c]    <= `STC_ZERO16;
        end
        else if (ce)
        begin
          if (loW)
            ocrBuf_reg[16*c+15:16*c] <= {temp_reg, wd};
          // double buffered in pwm: load at top
          if (!pwm || (go && atTop))
            ocr_reg[16*c+15:16*c] <= ocrBuf_reg[16*c+15:16*c];
        end
      end
      // waveform generator
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          compareOutputPins[c] <= 1'b0;
        else if (ce)
        begin
          if (off)
            compareOutputPins[c] <= 1'b0;
          else if (!pwm && (match[c] || forceStb[c]))
          begin
            case (com)
              2'b01:   compareOutputPins[c] <= ~compareOutputPins[c];
              2'b10:   compareOutputPins[c] <= 1'b0;
              2'b11:   compareOutputPins[c] <= 1'b1;
              default: compareOutputPins[c] <= compareOutputPins[c];
            endcase
          end
          else if (pwm && com[1] && match[c])
            compareOutputPins[c] <= com[0];
          else if (pwm && com[1] && go && atTop)
            compareOutputPins[c] <= ~com[0];
        end
      end
    end
  endgenerate

  // read data multiplexer
  reg [7:0] rd;
  always @*
  begin
    case (araddr)
      `STC_CTRLA: rd = ctrlA_reg;
      `STC_CTRLB: rd = ctrlB_reg;
      `STC_CTRLC: rd = ctrlC_reg;
      `STC_CNTL:  rd = cnt_reg[7:0];
      `STC_CNTH:  rd = temp_reg;
      8'h14:      rd = ocrBuf_reg[7:0];
      8'h18:      rd = ocrBuf_reg[15:8];     // bypasses latch
      8'h1C:      rd = ocrBuf_reg[23:16];
      8'h20:      rd = ocrBuf_reg[31:24];
      8'h24:      rd = ocrBuf_reg[39:32];
      8'h28:      rd = ocrBuf_reg[47:40];
      `STC_ICRL:  rd = icr_reg[7:0];
      `STC_ICRH:  rd = temp_reg;
      `STC_FLAGS: rd = {2'b00, flag_reg};
      `STC_MASK:  rd = mask_reg;
      `STC_PWR:   rd = {7'h00, pwr_reg};
      default:    rd = `STC_ZERO8;
    endcase
  end

  // axi4-lite write and read channels
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wHeld_reg  <= 1'b0;
      wData_reg  <= 8'h00;
      wStrb_reg  <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `STC_OKAY;
      rvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= `STC_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata[7:0];
        wStrb_reg <= wstrb[0];
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= mapped(awAddr_reg) ? `STC_OKAY : `STC_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (doRead)
      begin
        rvalid <= 1'b1;
        rdata  <= {24'h00_0000, rd};
        rresp  <= mapped(araddr) ? `STC_OKAY : `STC_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule

// ### shared/stc_regs.vh
`ifndef STC_REGS_VH
`define STC_REGS_VH
// register byte addresses
`define STC_CTRLA   8'h00
`define STC_CTRLB   8'h04
`define STC_CTRLC   8'h08
`define STC_CNTL    8'h0C
`define STC_CNTH    8'h10
`define STC_OCRL0   8'h14
`define STC_ICRL    8'h2C
`define STC_ICRH    8'h30
`define STC_FLAGS   8'h34
`define STC_MASK    8'h38
`define STC_PWR     8'h3C
// control fields
`define STC_WGMLO_LSB  0
`define STC_WGMHI_LSB  3
`define STC_CS_LSB     0
`define STC_EDGE_BIT   6
`define STC_FILT_BIT   7
`define STC_ACSEL_BIT  0
// flag positions
`define STC_F_OVF   0
`define STC_F_CMPA  1
`define STC_F_CAP   5
`define STC_FLAG_USED  6'h2F
// count limits
`define STC_BOTTOM  16'h0000
`define STC_MAX     16'hFFFF
`define STC_TOP8    16'h00FF
`define STC_TOP9    16'h01FF
`define STC_TOP10   16'h03FF
// reset values
`define STC_ZERO8   8'h00
`define STC_ZERO16  16'h0000
`define STC_PWR_RST 1'b1
// bus answers
`define STC_OKAY    2'b00
`define STC_SLVERR  2'b10
`endif

// ### testbench/stc_timer_core_sva.sv
`timescale 1ns/1ps
`include "stc_regs.vh"
module stc_timer_core_sva (
  input wire        clk,
  input wire        arst_n,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready,
  input wire [5:0]  irqRequest
);
  // one clock domain, reset masks all checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // control bytes carry no upper bits
  property p_rdata_byte; rvalid |-> rdata[31:8] == 24'h00_0000; endproperty
  a_rdata_byte: assert property (p_rdata_byte) else $error("read data above byte");
  property p_read_lat; arvalid && arready |=> rvalid; endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_write_lat; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
  a_write_lat: assert property (p_write_lat) else $error("write answer late");
  property p_slverr_zero; rvalid && rresp == `STC_SLVERR |-> rdata == 32'h0000_0000; endproperty
  a_slverr_zero: assert property (p_slverr_zero) else $error("refused read has data");
  property p_aw_block; bvalid |-> !awready && !wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during answer");
  property p_ar_block; rvalid |-> !arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
  property p_r_drop; rvalid && rready |=> !rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_b_drop; bvalid && bready |=> !bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  // reserved flag position never requests
  property p_irq_rsvd; irqRequest[4] == 1'b0; endproperty
  a_irq_rsvd: assert property (p_irq_rsvd) else $error("reserved request set");
  c_write: cover property (bvalid && bready);
  c_refuse: cover property (rvalid && rresp == `STC_SLVERR);
  c_irq: cover property (irqRequest != 6'h00);
endmodule
bind stc_timer_core stc_timer_core_sva sva_u (.clk(clk), .arst_n(arst_n), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .irqRequest(irqRequest));

// ### testbench/stc_cpu_model.sv
`timescale 1ns/1ps
module stc_cpu_model (
  input  wire        clk,
  output reg  [7:0]  awaddr,
  output reg         awvalid,
  input  wire        awready,
  output reg  [31:0] wdata,
  output reg  [3:0]  wstrb,
  output reg         wvalid,
  input  wire        wready,
  input  wire        bvalid,
  output reg         bready,
  output reg  [7:0]  araddr,
  output reg         arvalid,
  input  wire        arready,
  input  wire [31:0] rdata,
  input  wire [1:0]  rresp,
  input  wire        rvalid,
  output reg         rready
);
  integer n;    // edges waited
  reg     done; // answer seen
  reg     hung; // a wait ran out
  // idle bus, answers always accepted
  initial
  begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
    hung = 1'b0;
  end
  // one byte write, both channels offered together
  task wr(input [7:0] a, input [7:0] v);
    begin
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 100 && !done; n = n + 1)
      begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) done = 1'b1;
      end
      hung = hung | !done;
    end
  endtask
  // one byte read with its response code
  task rd(input [7:0] a, output [7:0] v, output [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 100 && !done; n = n + 1)
      begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) done = 1'b1;
      end
      v = rdata[7:0];
      r = rresp;
      hung = hung | !done;
    end
  endtask
endmodule

// ### testbench/stc_timer_core_test.sv
`timescale 1ns/1ps
`include "stc_regs.vh"
module stc_timer_core_test;
  reg         clk;      // 100 MHz
  reg         arst_n;   // async reset
  reg         capPin;   // capture trigger
  reg  [5:0]  ack;      // vector clears
  wire [7:0]  awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0]  wstrb;
  wire [1:0]  bresp, rresp;
  wire [2:0]  pins;
  wire [5:0]  irq;
  wire        awvalid, awready, wvalid, wready, bvalid, bready;
  wire        arvalid, arready, rvalid, rready;
  reg  [7:0]  d;
  reg  [1:0]  r;
  integer     fail_count, tests_run, i;
  always #5 clk = ~clk;
  stc_timer_core dut_u (.clk(clk), .arst_n(arst_n), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .extCountPin(1'b0), .captureInputPin(capPin), .compOutPin(1'b0),
    .irqAck(ack), .compareOutputPins(pins), .irqRequest(irq));
  stc_cpu_model cpu_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
      if (cpu_u.hung)
        print_verdict;
    end
  endtask
  // write; a hung bus ends the run
  task w(input [7:0] a, input [7:0] v);
    begin
      cpu_u.wr(a, v);
      if (cpu_u.hung)
        chk(32'h0000_0000, 32'h0000_0001, "bus hang");
    end
  endtask
  // read and compare byte plus response
  task rc(input [7:0] a, input [7:0] e, input [1:0] er, input [8*10:1] what);
    begin
      cpu_u.rd(a, d, r);
      chk({22'h0, r, d}, {22'h0, er, e}, what);
    end
  endtask
  // poll the flags until a bit shows, bounded
  task poll(input [7:0] m);
    begin
      d = 8'h00;
      for (i = 0; i < 60 && (d & m) == 8'h00; i = i + 1)
        cpu_u.rd(`STC_FLAGS, d, r);
      chk({24'h0, d & m}, {24'h0, m}, "flag wait");
    end
  endtask
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    capPin = 1'b0;
    ack = 6'h00;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rc(`STC_PWR, 8'h01, `STC_OKAY, "gate rst");
    rc(8'h40, 8'h00, `STC_SLVERR, "unmapped");
    w(8'h40, 8'h55);
    chk({30'h0, bresp}, {30'h0, `STC_SLVERR}, "wr refuse");
    w(`STC_PWR, 8'h00);
    w(`STC_CTRLA, 8'hA4);
    rc(`STC_CTRLA, 8'hA4, `STC_OKAY, "ctrlA");
    w(`STC_CTRLA, 8'h00);
    w(`STC_CTRLC, 8'hE0);
    rc(`STC_CTRLC, 8'h00, `STC_OKAY, "ctrlC");
    // stopped counter keeps a 16-bit value
    w(`STC_CNTH, 8'h12);
    w(`STC_CNTL, 8'h34);
    repeat (20) @(posedge clk);
    rc(`STC_CNTL, 8'h34, `STC_OKAY, "cnt lo");
    rc(`STC_CNTH, 8'h12, `STC_OKAY, "cnt hi");
    // compare high byte read bypasses the shared latch
    w(8'h18, 8'h00);
    w(`STC_OCRL0, 8'h40);
    rc(`STC_CNTL, 8'h34, `STC_OKAY, "cnt lo");
    rc(8'h18, 8'h00, `STC_OKAY, "ocrA hi");
    // masked match, then unmasked, then cleared
    w(`STC_CNTH, 8'h00);
    w(`STC_CNTL, 8'h30);
    w(`STC_CTRLA, 8'hC0);
    w(`STC_CTRLB, 8'h01);
    poll(8'h02);
    chk({29'h0, pins}, 32'h0000_0001, "pin set");
    chk({26'h0, irq}, 32'h0000_0000, "irq mask");
    w(`STC_MASK, 8'h22);
    chk({26'h0, irq}, 32'h0000_0002, "irq cmpA");
    w(`STC_FLAGS, 8'h02);
    rc(`STC_FLAGS, 8'h00, `STC_OKAY, "flag clr");
    // filtered capture: spike ignored, edge taken
    w(`STC_CTRLB, 8'hC0);
    w(`STC_CNTH, 8'h0A);
    w(`STC_CNTL, 8'hBC);
    capPin <= 1'b1;
    @(posedge clk);
    capPin <= 1'b0;
    repeat (12) @(posedge clk);
    rc(`STC_FLAGS, 8'h00, `STC_OKAY, "spike");
    capPin <= 1'b1;
    poll(8'h20);
    rc(`STC_ICRL, 8'hBC, `STC_OKAY, "icr lo");
    rc(`STC_ICRH, 8'h0A, `STC_OKAY, "icr hi");
    ack <= 6'h20;
    @(posedge clk);
    ack <= 6'h00;
    rc(`STC_FLAGS, 8'h00, `STC_OKAY, "ack clr");
    // fixed top 0x00FF wraps below 0x0100
    w(`STC_CTRLB, 8'h00);
    w(`STC_CNTH, 8'h00);
    w(`STC_CNTL, 8'hF0);
    w(`STC_CTRLA, 8'h01);
    w(`STC_CTRLB, 8'h01);
    poll(8'h01);
    cpu_u.rd(`STC_CNTL, d, r);
    chk({31'h0, d < 8'h40}, 32'h0000_0001, "wrap lo");
    rc(`STC_CNTH, 8'h00, `STC_OKAY, "top wrap");
    print_verdict;
  end
endmodule
